// ==== verilog/robust_pdu_framer.v ====
// transmit framer for the robust pdu: header, coded user data, multi-dwell packets
//
// Summary of operation
// - scramble, then convolutional code, then packetise
// - robust header goes out before everything else
// - format field bch coded, five copies sent
// - scramble and code only when format selects
// - each octet leaves least significant bit first
// - multi-dwell flag set in format field
// - 64-bit segments, 6/11/13 per packet
// - packet ends with start pattern then counter
// - segment counter bch(15,7) coded before appending
// - format picks copies, pattern length, segments
// - flag clear: no segments, no packets
// - flag clear: only sync and format field precede
//
// Added by the designer: the address-and-strobe port and the register offsets.
`include "robust_pdu_framer_regs.vh"

module robust_pdu_framer (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata,
    // octet stream from the upper layer
    input  wire [7:0]  dataIn,
    input  wire        dataValid,
    output reg         dataReady,
    // serial bit stream to the physical layer
    output reg         txBit,
    output reg         txValid,
    input  wire        txReady
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SYNC = 3'h1;
    localparam [2:0] ST_FMT  = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_PAD  = 3'h4;
    localparam [2:0] ST_PAT  = 3'h5;
    localparam [2:0] ST_CNT  = 3'h6;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg [5:0]  ctrlQ;         // software options
    reg [15:0] lengthQ;       // octets per transmission
    reg        scrQ;          // options frozen at start
    reg        convQ;
    reg        mdQ;
    reg [1:0]  fmtQ;
    reg [2:0]  stateQ, stateD;
    reg [63:0] fieldQ, fieldD;     // field being shifted out
    reg [6:0]  fieldLenQ, fieldLenD;
    reg [2:0]  copyQ, copyD;       // copies sent of current field
    reg [15:0] octLeftQ, octLeftD; // octets still to fetch
    reg [7:0]  octQ, octD;         // octet being serialised
    reg [3:0]  octBitsQ, octBitsD; // bits left in octQ
    reg [6:0]  lfsrQ, lfsrD;       // scrambler state
    reg [5:0]  convShQ, convShD;   // coder history
    reg        pendQ, pendD;       // second coded bit waiting
    reg        pendBitQ, pendBitD;
    reg [5:0]  segBitQ, segBitD;   // bit within segment
    reg [3:0]  segCntQ, segCntD;   // segments in current group
    reg [6:0]  pktQ, pktD;         // segment counter value
    reg        txValidD, txBitD, dataReadyD;

    // ----------------------------------------------------------------
    // format dependent figures
    // ----------------------------------------------------------------
    reg [3:0]  segsPerPkt;  // segments per packet
    reg [2:0]  cntCopies;   // counter copies per packet
    reg [63:0] patWord;     // start of packet pattern
    reg [6:0]  patLen;

    // format picks segments per packet, counter copies and start pattern; segment length stays 64 bits
    always @* begin
        case (fmtQ)
            2'h0: begin
                segsPerPkt = `SEGS_FMT0;
                cntCopies  = `CNT_COPIES_FMT0;
                patWord    = `PAT_SHORT;
                patLen     = `PAT_SHORT_BITS;
            end
            2'h1: begin
                segsPerPkt = `SEGS_FMT1;
                cntCopies  = `CNT_COPIES_FMT1;
                patWord    = `PAT_LONG;
                patLen     = `PAT_LONG_BITS;
            end
            default: begin  // code 3 behaves as code 2
                segsPerPkt = `SEGS_FMT2;
                cntCopies  = `CNT_COPIES_FMT2;
                patWord    = `PAT_LONG;
                patLen     = `PAT_LONG_BITS;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // bch coders for format field and segment counter
    // ----------------------------------------------------------------
    wire [6:0]  fmtWord = {2'b00, fmtQ, mdQ, convQ, scrQ};
    wire [14:0] fmtCode;
    wire [14:0] cntCode;

    bch15_7_encoder fmtEnc (
        .message  (fmtWord),
        .codeword (fmtCode)
    );

    bch15_7_encoder cntEnc (
        .message  (pktQ),
        .codeword (cntCode)
    );

    // ----------------------------------------------------------------
    // source bit path: scramble first, code second
    // ----------------------------------------------------------------
    wire       srcBit  = octQ[0];
    wire       scrBit  = srcBit ^ (scrQ & (lfsrQ[6] ^ lfsrQ[3]));
    wire [6:0] convIn  = {scrBit, convShQ};
    wire       g1      = ^(convIn & `CONV_G1);
    wire       g2      = ^(convIn & `CONV_G2);
    wire       startReq = regWr && (regAddr == `REG_CTRL) && regWdata[`CTRL_START];
    wire       canLoad = !txValid || txReady;  // output slot free
    wire       octetIn = dataReady && dataValid;
    wire       dataDone = (octLeftQ == 16'h0000) && (octBitsQ == 4'h0) && !pendQ;

    // ----------------------------------------------------------------
    // sequencer: picks the next output bit and the next state
    // ----------------------------------------------------------------
    always @* begin
        stateD     = stateQ;
        fieldD     = fieldQ;
        fieldLenD  = fieldLenQ;
        copyD      = copyQ;
        octLeftD   = octLeftQ;
        octD       = octQ;
        octBitsD   = octBitsQ;
        lfsrD      = lfsrQ;
        convShD    = convShQ;
        pendD      = pendQ;
        pendBitD   = pendBitQ;
        segBitD    = segBitQ;
        segCntD    = segCntQ;
        pktD       = pktQ;
        txValidD   = txValid && !txReady;
        txBitD     = txBit;
        // a fresh octet lands in the serialiser
        if (octetIn) begin
            octD     = dataIn;
            octBitsD = 4'h8;
            octLeftD = octLeftQ - 16'h0001;
        end
        case (stateQ)
            ST_IDLE: begin
                // start is ignored while a unit is in flight
                if (startReq) begin
                    stateD    = ST_SYNC;
                    fieldD    = {32'h0000_0000, `SYNC_PATTERN};
                    fieldLenD = `SYNC_BITS;
                    octLeftD  = lengthQ;
                    octBitsD  = 4'h0;
                    lfsrD     = `LFSR_SEED;
                    convShD   = 6'h00;
                    pendD     = 1'b0;
                    segBitD   = 6'h00;
                    segCntD   = 4'h0;
                    pktD      = 7'h00;
                    copyD     = 3'h0;
                end
            end
            ST_SYNC, ST_FMT, ST_PAT, ST_CNT: begin
                // fields leave least significant bit first
                if (canLoad) begin
                    txValidD  = 1'b1;
                    txBitD    = fieldQ[0];
                    fieldD    = {1'b0, fieldQ[63:1]};
                    fieldLenD = fieldLenQ - 7'h01;
                    if (fieldLenQ == 7'h01) begin
                        copyD = copyQ + 3'h1;
                        case (stateQ)
                            ST_SYNC: begin
                                stateD    = ST_FMT;
                                fieldD    = {49'h0, fmtCode};
                                fieldLenD = `BCH_BITS;
                                copyD     = 3'h0;
                            end
                            ST_FMT: begin
                                // five copies feed a 3-of-5 vote
                                if (copyQ + 3'h1 < `FMT_COPIES) begin
                                    fieldD    = {49'h0, fmtCode};
                                    fieldLenD = `BCH_BITS;
                                end else begin
                                    stateD = ST_DATA;
                                end
                            end
                            ST_PAT: begin
                                stateD    = ST_CNT;
                                fieldD    = {49'h0, cntCode};
                                fieldLenD = `BCH_BITS;
                                copyD     = 3'h0;
                            end
                            default: begin  // counter field
                                if (copyQ + 3'h1 < cntCopies) begin
                                    fieldD    = {49'h0, cntCode};
                                    fieldLenD = `BCH_BITS;
                                end else begin
                                    pktD    = pktQ + 7'h01;
                                    segCntD = 4'h0;
                                    stateD  = dataDone ? ST_IDLE : ST_DATA;
                                end
                            end
                        endcase
                    end
                end
            end
            ST_DATA, ST_PAD: begin
                if (stateQ == ST_DATA && dataDone) begin
                    // a partial segment or group still needs closing
                    if (mdQ && segBitQ != 6'h00) begin
                        stateD = ST_PAD;
                    end else if (mdQ && segCntQ != 4'h0) begin
                        stateD    = ST_PAT;
                        fieldD    = patWord;
                        fieldLenD = patLen;
                    end else begin
                        stateD = ST_IDLE;
                    end
                end else if (canLoad && (pendQ || octBitsQ != 4'h0 || stateQ == ST_PAD)) begin
                    txValidD = 1'b1;
                    if (stateQ == ST_PAD) begin
                        txBitD = 1'b0;
                    end else if (pendQ) begin
                        txBitD = pendBitQ;
                        pendD  = 1'b0;
                    end else begin
                        // consume one source bit
                        octD     = {1'b0, octQ[7:1]};
                        octBitsD = octBitsQ - 4'h1;
                        lfsrD    = {lfsrQ[5:0], lfsrQ[6] ^ lfsrQ[3]};
                        if (convQ) begin
                            txBitD   = g1;
                            convShD  = convIn[6:1];
                            pendD    = 1'b1;
                            pendBitD = g2;
                        end else begin
                            txBitD = scrBit;
                        end
                    end
                    // segments counted on the coded stream
                    if (mdQ) begin
                        segBitD = segBitQ + 6'h01;
                        if (segBitQ == `SEG_BITS) begin
                            if (stateQ == ST_PAD || segCntQ + 4'h1 == segsPerPkt) begin
                                stateD    = ST_PAT;
                                fieldD    = patWord;
                                fieldLenD = patLen;
                                segCntD   = segCntQ + 4'h1;
                            end else begin
                                segCntD = segCntQ + 4'h1;
                            end
                        end
                    end
                end
            end
            default: begin
                stateD = ST_IDLE;
            end
        endcase
        // ask for an octet only when the serialiser is empty in data state
        dataReadyD = (stateD == ST_DATA) && (octBitsD == 4'h0) &&
                     (octLeftD != 16'h0000) && !octetIn;
    end

    // ----------------------------------------------------------------
    // sequencer registers
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stateQ    <= ST_IDLE;
            fieldQ    <= 64'h0;
            fieldLenQ <= 7'h00;
            copyQ     <= 3'h0;
            octLeftQ  <= 16'h0000;
            octQ      <= 8'h00;
            octBitsQ  <= 4'h0;
            lfsrQ     <= `LFSR_SEED;
            convShQ   <= 6'h00;
            pendQ     <= 1'b0;
            pendBitQ  <= 1'b0;
            segBitQ   <= 6'h00;
            segCntQ   <= 4'h0;
            pktQ      <= 7'h00;
            txValid   <= 1'b0;
            txBit     <= 1'b0;
            dataReady <= 1'b0;
        end else begin
            stateQ    <= stateD;
            fieldQ    <= fieldD;
            fieldLenQ <= fieldLenD;
            copyQ     <= copyD;
            octLeftQ  <= octLeftD;
            octQ      <= octD;
            octBitsQ  <= octBitsD;
            lfsrQ     <= lfsrD;
            convShQ   <= convShD;
            pendQ     <= pendD;
            pendBitQ  <= pendBitD;
            segBitQ   <= segBitD;
            segCntQ   <= segCntD;
            pktQ      <= pktD;
            txValid   <= txValidD;
            txBit     <= txBitD;
            dataReady <= dataReadyD;
        end
    end

    // ----------------------------------------------------------------
    // register port: writes, option snapshot, read data one cycle later
    // ----------------------------------------------------------------
    // options are frozen at start so a mid-frame write cannot split a unit
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrlQ    <= `CTRL_RESET;
            lengthQ  <= `LENGTH_RESET;
            scrQ     <= 1'b0;
            convQ    <= 1'b0;
            mdQ      <= 1'b0;
            fmtQ     <= 2'b00;
            regRdata <= 32'h0000_0000;
        end else begin
            if (regWr && regAddr == `REG_CTRL) begin
                ctrlQ <= {regWdata[`CTRL_FMT_HI:`CTRL_SCRAMBLE], 1'b0};
            end
            if (regWr && regAddr == `REG_LENGTH && stateQ == ST_IDLE) begin
                lengthQ <= regWdata[15:0];
            end
            if (stateQ == ST_IDLE && startReq) begin
                scrQ  <= regWdata[`CTRL_SCRAMBLE];
                convQ <= regWdata[`CTRL_CONVCODE];
                mdQ   <= regWdata[`CTRL_MULTIDWELL];
                fmtQ  <= regWdata[`CTRL_FMT_HI:`CTRL_FMT_LO];
            end
            if (regRd) begin
                case (regAddr)
                    `REG_CTRL:     regRdata <= {26'h0, ctrlQ};
                    `REG_LENGTH:   regRdata <= {16'h0, lengthQ};
                    `REG_STATUS:   regRdata <= {13'h0, stateQ, octLeftQ};
                    `REG_PKTCOUNT: regRdata <= {25'h0, pktQ};
                    default:       regRdata <= 32'h0000_0000;
                endcase
            end else begin
                regRdata <= 32'h0000_0000;
            end
        end
    end

endmodule // robust_pdu_framer

// ==== common/robust_pdu_framer_regs.vh ====
// register map, field positions, reset values and framing constants of the robust pdu framer
`ifndef ROBUST_PDU_FRAMER_REGS_VH
`define ROBUST_PDU_FRAMER_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL         8'h00
`define REG_LENGTH       8'h04
`define REG_STATUS       8'h08
`define REG_PKTCOUNT     8'h0C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_START       0
`define CTRL_SCRAMBLE    1
`define CTRL_CONVCODE    2
`define CTRL_MULTIDWELL  3
`define CTRL_FMT_LO      4
`define CTRL_FMT_HI      5
`define CTRL_RESET       6'h00
`define LENGTH_RESET     16'h0000

// ----------------------------------------------------------------
// framing constants
// ----------------------------------------------------------------
`define SYNC_PATTERN     32'hB4E2_6D19
`define SYNC_BITS        7'h20
`define PAT_SHORT        64'h0000_0000_8E3A_57C4
`define PAT_LONG         64'hA5C3_1F96_4D2B_E870
`define PAT_SHORT_BITS   7'h20
`define PAT_LONG_BITS    7'h40
`define BCH_BITS         7'h0F
`define FMT_COPIES       3'h5
`define SEG_BITS         6'h3F
`define SEGS_FMT0        4'h6
`define SEGS_FMT1        4'hB
`define SEGS_FMT2        4'hD
`define CNT_COPIES_FMT0  3'h1
`define CNT_COPIES_FMT1  3'h3
`define CNT_COPIES_FMT2  3'h5
`define LFSR_SEED        7'h7F
`define CONV_G1          7'h79
`define CONV_G2          7'h5B
`define BCH_POLY         9'h1D1

`endif

// ==== verilog/bch15_7_encoder.v ====
// systematic bch(15,7) encoder: seven message bits above an eight-bit remainder
`include "robust_pdu_framer_regs.vh"

module bch15_7_encoder (
    // message in
    input  wire [6:0]  message,
    // codeword out
    output reg  [14:0] codeword
);

    reg [14:0] work;   // long division scratch
    integer    i;

    // ----------------------------------------------------------------
    // polynomial division of message * x^8
    // ----------------------------------------------------------------
    always @* begin
        work = {message, 8'h00};
        for (i = 14; i >= 8; i = i - 1) begin
            if (work[i]) begin
                work = work ^ ({6'h00, `BCH_POLY} << (i - 8));
            end
        end
        codeword = {message, work[7:0]};
    end

endmodule // bch15_7_encoder

// ==== verif/robust_pdu_framer_asserts.sv ====
// port-level assertion checker of the robust pdu framer
module robust_pdu_framer_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // register port
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    // octet stream
    input wire logic [7:0]  dataIn,
    input wire logic        dataValid,
    input wire logic        dataReady,
    // serial stream
    input wire logic        txBit,
    input wire logic        txValid,
    input wire logic        txReady
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // one clock domain, reset disables all
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // read data only in the cycle after a read strobe
    chk_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
        else $error("read data not zero outside read answer");
    chk_unmapped_zero: assert property (regRd && regAddr > 8'h0C |=> regRdata == 32'h0)
        else $error("unmapped read returned data");
    // start bit is write-only, upper control bits unused
    chk_ctrl_clean: assert property (regRd && regAddr == 8'h00 |=> regRdata[31:6] == 26'h0 && !regRdata[0])
        else $error("control read shows start or spare bits");
    chk_count_width: assert property (regRd && regAddr == 8'h0C |=> regRdata[31:7] == 25'h0)
        else $error("packet counter wider than seven bits");
    chk_status_width: assert property (regRd && regAddr == 8'h08 |=> regRdata[31:19] == 13'h0)
        else $error("status spare bits set");
    // a stalled bit must not change under the phy
    chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txBit))
        else $error("serial bit changed while stalled");
    // one octet per request
    chk_ready_drop: assert property (dataValid && dataReady |=> !dataReady)
        else $error("octet request stayed up after a take");
    chk_ready_stands: assert property (dataReady && !dataValid |=> dataReady)
        else $error("octet request withdrawn without a take");
endmodule // robust_pdu_framer_checker

bind robust_pdu_framer robust_pdu_framer_checker chk (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .dataIn(dataIn), .dataValid(dataValid), .dataReady(dataReady),
    .txBit(txBit), .txValid(txValid), .txReady(txReady)
);

// ==== verif/phy_sink_model.sv ====
// serial sink standing for the radio physical layer
module phy_sink_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // serial stream
    input  wire logic txBit,
    input  wire logic txValid,
    output logic      txReady,
    // pacing: when set, takes one bit in four
    input  wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       bits [$]; // every bit taken, in order
    logic [1:0] pace;     // stall pattern counter

    // ----------------------------------------
    // take bits, stalling when asked so held bits are exercised
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txReady <= 1'b0;
            pace    <= 2'h0;
        end else begin
            pace    <= pace + 2'h1;
            txReady <= !slow || pace == 2'h1;
            if (txValid && txReady)
                bits.push_back(txBit);
        end
    end
endmodule // phy_sink_model

// ==== verif/robust_pdu_framer_test.sv ====
// self-checking bench of the robust pdu framer
`include "robust_pdu_framer_regs.vh"
`define CHECK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin nMismatch++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module robust_pdu_framer_test;
    timeunit 1ns;
    timeprecision 1ps;
    // design ports
    logic        clk, rstn, regWr, regRd, dataValid, dataReady, txBit, txValid, txReady, slow;
    logic [7:0]  regAddr, dataIn;
    logic [31:0] regWdata, regRdata, d;
    // bench state
    int          nMismatch = 0;
    int          totalChecks = 0;
    int          srcLen, srcIdx;
    logic [7:0]  srcBuf [0:127];
    logic        expQ [$];

    robust_pdu_framer DUT (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .dataIn(dataIn), .dataValid(dataValid), .dataReady(dataReady),
        .txBit(txBit), .txValid(txValid), .txReady(txReady));
    phy_sink_model ph (.clk(clk), .rstn(rstn), .txBit(txBit), .txValid(txValid), .txReady(txReady), .slow(slow));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // octet source, paced by the sink when slow so a waiting request is seen;
    // idle data toggles so stale bytes never look valid
    // ----------------------------------------
    always @(posedge clk) begin
        if (dataValid && dataReady)
            srcIdx = srcIdx + 1;
        dataValid <= srcIdx < srcLen && (!slow || ph.pace == 2'h2);
        dataIn    <= (srcIdx < srcLen) ? srcBuf[srcIdx[6:0]] : ~dataIn;
    end

    // ----------------------------------------
    // register bus and expectation helpers
    // ----------------------------------------
    task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= v;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask

    task automatic regRead(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1 v = regRdata;
    endtask

    function automatic logic [14:0] bch(input logic [6:0] m);
        logic [14:0] r;
        r = {m, 8'h00};
        for (int i = 14; i >= 8; i--)
            if (r[i]) r = r ^ (15'(`BCH_POLY) << (i - 8));
        return {m, r[7:0]};
    endfunction

    task automatic pushBits(input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++) expQ.push_back(v[i]);
    endtask

    // sync then five coded copies of the format field
    task automatic buildHeader(input logic s, input logic c, input logic m, input logic [1:0] f);
        expQ.delete();
        pushBits(64'(`SYNC_PATTERN), 32);
        repeat (5) pushBits(64'(bch({2'b00, f, m, c, s})), 15);
    endtask

    // plain data, or padded segments with pattern and counter per group
    task automatic buildData(input int n, input logic m, input logic [1:0] f);
        int g, c, nb;
        g  = (f == 2'h0) ? 6 : (f == 2'h1) ? 11 : 13;
        nb = m ? ((n * 8 + 63) / 64) * 64 : n * 8;
        c  = 0;
        for (int b = 0; b < nb; b++) begin
            expQ.push_back(b < n * 8 ? srcBuf[b / 8][b % 8] : 1'b0);
            if (m && b % 64 == 63 && ((b / 64) % g == g - 1 || b == nb - 1)) begin
                pushBits(f == 2'h0 ? `PAT_SHORT : `PAT_LONG, f == 2'h0 ? 32 : 64);
                repeat (f == 2'h0 ? 1 : f == 2'h1 ? 3 : 5) pushBits(64'(bch(7'(c))), 15);
                c++;
            end
        end
    endtask

    // start one unit and wait, bounded, until the framer is idle again
    task automatic runFrame(input logic s, input logic c, input logic m, input logic [1:0] f, input int n,
                            input logic p);
        int k;
        srcLen = 0;
        srcIdx = 0;
        for (k = 0; k < n; k++) srcBuf[k] = 8'(k * 37 + 5);
        slow = p;
        ph.bits.delete();
        srcLen = n;
        regWrite(`REG_LENGTH, 32'(n));
        regWrite(`REG_CTRL, {26'h0, f, m, c, s, 1'b1});
        k = 0;
        do begin
            regRead(`REG_STATUS, d);
            k++;
        end while (d[18:16] != 3'h0 && k < 20000);
        if (d[18:16] != 3'h0) nMismatch++; // unit never finished
        repeat (4) @(posedge clk);
    endtask

    task automatic compareStream();
        `CHECK(ph.bits.size(), expQ.size())
        for (int i = 0; i < expQ.size(); i++) `CHECK(ph.bits[i], expQ[i])
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic testRegs();
        for (int a = 0; a < 5; a++) begin
            regRead(a == 4 ? 8'h40 : 8'(a * 4), d);
            `CHECK(d, 32'h0)
        end
        regWrite(`REG_LENGTH, 32'h0000_1234);
        regRead(`REG_LENGTH, d);
        `CHECK(d, 32'h0000_1234)
    endtask

    task automatic testPlain();
        runFrame(1'b0, 1'b0, 1'b0, 2'h0, 3, 1'b1);
        buildHeader(1'b0, 1'b0, 1'b0, 2'h0);
        buildData(3, 1'b0, 2'h0);
        compareStream();
    endtask

    task automatic testOptions();
        int diff;
        for (int m = 1; m < 4; m++) begin
            runFrame(m[0], m[1], 1'b0, 2'h1, 2, 1'b0);
            buildHeader(m[0], m[1], 1'b0, 2'h1);
            buildData(2, 1'b0, 2'h0);
            `CHECK(ph.bits.size(), expQ.size() + (m[1] ? 16 : 0))
            for (int k = 0; k < 107; k++) `CHECK(ph.bits[k], expQ[k])
            diff = 0;
            for (int k = 107; k < 123; k++) diff += (ph.bits[k] !== expQ[k]);
            `CHECK(diff != 0, 1'b1)
        end
    endtask

    task automatic testMultiDwell();
        int n;
        for (int f = 0; f < 4; f++) begin
            n = (f == 0 ? 6 : f == 1 ? 11 : 13) * 8 + 3;
            runFrame(1'b0, 1'b0, 1'b1, f[1:0], n, f[0]);
            buildHeader(1'b0, 1'b0, 1'b1, f[1:0]);
            buildData(n, 1'b1, f[1:0]);
            compareStream();
            regRead(`REG_PKTCOUNT, d);
            `CHECK(d, 32'h2)
        end
    endtask

    task automatic stopTest();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        rstn      = 1'b0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        regAddr   = 8'h00;
        regWdata  = 32'h0;
        dataValid = 1'b0;
        dataIn    = 8'h00;
        slow      = 1'b0;
        srcLen    = 0;
        srcIdx    = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        testRegs();
        testPlain();
        testOptions();
        testMultiDwell();
        stopTest();
    end

    // whole run needs well under 60k cycles
    initial begin
        #2000000;
        nMismatch++;
        stopTest();
    end
endmodule // robust_pdu_framer_test
